// ==== srq_pkg.sv ====
package srq_pkg;
  // Status byte values, as presented at serial poll
  localparam logic [7:0] STB_NONE = 8'h00;
  localparam logic [7:0] STB_POWER_ON = 8'h41;
  localparam logic [7:0] STB_OP_COMPLETE = 8'h42;
  localparam logic [7:0] STB_USER_REQ = 8'h43;
  localparam logic [7:0] STB_SUPPLY_RECOVER = 8'h45;
  localparam logic [7:0] STB_CMD_ERROR = 8'h61;
  localparam logic [7:0] STB_EXEC_ERROR = 8'h62;
  localparam logic [7:0] STB_INTERNAL_ERROR = 8'h63;
  localparam logic [7:0] STB_DEVICE_EVENT = 8'hC0;
  // Field positions within the status byte (bit 1 of the byte is index 0)
  localparam int CODE_LSB = 0;
  localparam int CODE_W = 4;
  localparam int ABNORMAL_BIT = 5;
  localparam int SRQ_BIT = 6;
  // Event codes
  localparam logic [9:0] EVC_NONE = 10'h000;
  localparam logic [9:0] EVC_MEAS_SIGNAL = 10'h192;
  localparam logic [9:0] EVC_MEAS_SWEEP = 10'h196;
  // Depth of the event code store
  localparam int LIFO_DEPTH = 10;
  // Reset values of the two enables
  localparam logic RQS_RESET = 1'b1;
  localparam logic OPC_RESET = 1'b1;
  // Event source indices, lowest index wins when several arrive together
  localparam int EV_W = 9;
  localparam int EV_POWER = 0;
  localparam int EV_INTERNAL = 1;
  localparam int EV_EXEC = 2;
  localparam int EV_CMD = 3;
  localparam int EV_RECOVER = 4;
  localparam int EV_USER = 5;
  localparam int EV_DEVICE = 6;
  localparam int EV_MEAS_SIG = 7;
  localparam int EV_MEAS_SWP = 8;
endpackage

// ==== event_lifo.sv ====
`timescale 1ns/1ps
// Last-in-first-out store of event codes; a push when full drops the oldest
module event_lifo
  import srq_pkg::*;
#(
  parameter int DEPTH = srq_pkg::LIFO_DEPTH,
  parameter int W = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Push and pop
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic pop,
  // State
  output logic [W-1:0] top_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  logic [W-1:0] mem_q [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] count_q;

  assign count = count_q;
  assign top_data = (count_q == '0) ? '0 : mem_q[0];

  // Entry 0 is the newest; shifting keeps pop and overflow trivial
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (push) begin
      mem_q[0] <= push_data;
      for (int i = 1; i < DEPTH; i++) begin
        mem_q[i] <= mem_q[i-1];
      end
      // Full store loses the oldest entry off the far end
      if (count_q != DEPTH[$clog2(DEPTH+1)-1:0]) begin
        count_q <= count_q + 1'b1;
      end
    end else if (pop && count_q != '0) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem_q[i] <= mem_q[i+1];
      end
      count_q <= count_q - 1'b1;
    end
  end
endmodule

// ==== status_pick.sv ====
`timescale 1ns/1ps
// Maps the highest-priority raised event to its status byte and event code
module status_pick
  import srq_pkg::*;
(
  // Event strobes
  input wire logic [srq_pkg::EV_W-1:0] ev,
  input wire logic [9:0] ev_code,
  // Result
  output logic hit,
  output logic [7:0] stb,
  output logic [9:0] code
);
  always_comb begin
    hit = |ev;
    stb = STB_NONE;
    code = EVC_NONE;
    for (int i = EV_W - 1; i >= 0; i--) begin
      if (ev[i]) begin
        code = ev_code;
        case (i)
          EV_POWER: stb = STB_POWER_ON;
          EV_INTERNAL: stb = STB_INTERNAL_ERROR;
          EV_EXEC: stb = STB_EXEC_ERROR;
          EV_CMD: stb = STB_CMD_ERROR;
          EV_RECOVER: stb = STB_SUPPLY_RECOVER;
          EV_USER: stb = STB_USER_REQ;
          EV_DEVICE: stb = STB_DEVICE_EVENT;
          EV_MEAS_SIG: begin
            stb = STB_OP_COMPLETE;
            code = EVC_MEAS_SIGNAL;
          end
          EV_MEAS_SWP: begin
            stb = STB_OP_COMPLETE;
            code = EVC_MEAS_SWEEP;
          end
          default: stb = STB_NONE;
        endcase
      end
    end
  end
endmodule

// ==== gpib_status_srq_reporter.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Drive SRQ while an event waits and service requests are enabled.
// - Serial poll returns a status byte naming the event category.
// - Answering a poll drops the pending request without any clear command.
// - The one pending unreported byte re-raises SRQ once the latest is polled; older bytes are lost.
// - Event query returns the decimal event code of the condition.
// - Keep only the latest status byte plus one pending byte.
// - Event codes sit in a ten-deep LIFO; queries return newest unread.
// - Masked general or completion requests wait until unmasked; a completion arriving masked queues its code but no status byte, and is never asserted.
// - With requests disabled, up to ten events still accumulate for queries.
// - Completion enable on raises status 66 on completion; off suppresses it.
// - Enable queries return only ON or OFF.
// - Category code sits in status bits 1 to 4.
// - Status bit 6 set for abnormal, clear for normal.
// - Status bit 7 shows SRQ asserted, depending on request enable.
// - No waiting event gives a status byte of zero.
// - Power cycle reports status 65.
// - Single-sweep pressed with fast/shift held reports status 67.
// - Phase-lock or overheat error clearing reports status 69.
// - Unparsable message reports status 97.
// - Recognized but unexecutable message reports status 98.
// - Detected malfunction reports status 99.
// - Instrument-specific event reports status 192.
// - Measure-signal done queues 402, measure-sweep done 406, both status 66.
module gpib_status_srq_reporter
  import srq_pkg::*;
#(
  parameter int DEPTH = srq_pkg::LIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Event sources, one-cycle strobes
  input wire logic power_on_ev,
  input wire logic internal_err_ev,
  input wire logic exec_err_ev,
  input wire logic cmd_err_ev,
  input wire logic supply_recover_ev,
  input wire logic single_btn,
  input wire logic fast_shift_held,
  input wire logic device_ev,
  input wire logic meas_signal_done,
  input wire logic meas_sweep_done,
  input wire logic [9:0] ev_code_in,
  // Parser commands, one-cycle strobes
  input wire logic service_request_enable_cmd,
  input wire logic completion_request_enable_cmd,
  input wire logic cmd_arg_on,
  input wire logic request_enable_query,
  input wire logic completion_enable_query,
  input wire logic event_query,
  input wire logic serial_poll,
  // Bus side
  output logic srq_out,
  output logic [7:0] serial_poll_status_byte,
  output logic poll_valid,
  // Query answers
  output logic [9:0] event_code,
  output logic event_valid,
  output logic enable_state,
  output logic enable_valid,
  // Observed state
  output logic rqs_enabled,
  output logic opc_enabled,
  output logic [$clog2(DEPTH+1)-1:0] events_stored
);
  logic [EV_W-1:0] ev;
  logic hit;
  logic [7:0] new_stb;
  logic [9:0] new_code;
  logic is_opc;
  logic push;
  logic [9:0] lifo_top;
  logic [$clog2(DEPTH+1)-1:0] lifo_count;
  logic rqs_q;
  logic opc_q;
  logic [7:0] latest_q;
  logic [7:0] pending_q;
  logic latest_v_q;
  logic pending_v_q;
  logic latest_opc_q;
  logic pending_opc_q;
  logic srq_q;
  logic [7:0] stb_q;
  logic poll_v_q;
  logic [9:0] evc_q;
  logic evc_v_q;
  logic en_q;
  logic en_v_q;
  logic [$clog2(DEPTH+1)-1:0] cnt_q;
  logic req_ok;

  // Gather the event strobes
  assign ev[EV_POWER] = power_on_ev;
  assign ev[EV_INTERNAL] = internal_err_ev;
  assign ev[EV_EXEC] = exec_err_ev;
  assign ev[EV_CMD] = cmd_err_ev;
  assign ev[EV_RECOVER] = supply_recover_ev;
  assign ev[EV_USER] = single_btn & fast_shift_held;
  assign ev[EV_DEVICE] = device_ev;
  assign ev[EV_MEAS_SIG] = meas_signal_done;
  assign ev[EV_MEAS_SWP] = meas_sweep_done;

  status_pick u_pick (
    .ev(ev),
    .ev_code(ev_code_in),
    .hit(hit),
    .stb(new_stb),
    .code(new_code)
  );

  assign is_opc = (new_stb == STB_OP_COMPLETE);
  // Codes always queue, even with requests disabled
  assign push = hit;

  event_lifo #(.DEPTH(DEPTH), .W(10)) u_lifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .push(push),
    .push_data(new_code),
    .pop(event_query & ~push),
    .top_data(lifo_top),
    .count(lifo_count)
  );

  // Enables, written by the command parser
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rqs_q <= RQS_RESET;
      opc_q <= OPC_RESET;
    end else begin
      if (service_request_enable_cmd) begin
        rqs_q <= cmd_arg_on;
      end
      if (completion_request_enable_cmd) begin
        opc_q <= cmd_arg_on;
      end
    end
  end

  // Two-slot status store; a new byte always wins over a poll in the same cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latest_q <= STB_NONE;
      pending_q <= STB_NONE;
      latest_v_q <= 1'b0;
      pending_v_q <= 1'b0;
      latest_opc_q <= 1'b0;
      pending_opc_q <= 1'b0;
    end else if (hit && !(is_opc && !opc_q)) begin
      // Older bytes beyond two are lost
      latest_q <= new_stb;
      latest_opc_q <= is_opc;
      latest_v_q <= 1'b1;
      if (serial_poll) begin
        pending_v_q <= 1'b0;
      end else begin
        pending_q <= latest_q;
        pending_opc_q <= latest_opc_q;
        pending_v_q <= latest_v_q;
      end
    end else if (serial_poll && latest_v_q) begin
      // Poll consumes the latest; the pending one moves up
      latest_q <= pending_q;
      latest_opc_q <= pending_opc_q;
      latest_v_q <= pending_v_q;
      pending_v_q <= 1'b0;
    end
  end

  // A request may go out only if its own mask allows it
  assign req_ok = latest_v_q && rqs_q && !(latest_opc_q && !opc_q);

  // SRQ line and its follow-on reassertion
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      srq_q <= 1'b0;
    end else if (serial_poll) begin
      srq_q <= 1'b0;
    end else begin
      srq_q <= req_ok;
    end
  end

  // Serial poll answer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stb_q <= STB_NONE;
      poll_v_q <= 1'b0;
    end else begin
      poll_v_q <= serial_poll;
      if (serial_poll) begin
        if (!latest_v_q) begin
          stb_q <= STB_NONE;
        end else begin
          // Bit 7 reflects whether the request was really raised
          stb_q <= {latest_q[7], srq_q, latest_q[5:0]};
        end
      end
    end
  end

  // Event query answer; an empty store answers zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evc_q <= EVC_NONE;
      evc_v_q <= 1'b0;
    end else begin
      evc_v_q <= event_query;
      if (event_query) begin
        evc_q <= lifo_top;
      end
    end
  end

  // Enable queries carry only the on/off flag
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_q <= 1'b0;
      en_v_q <= 1'b0;
    end else begin
      en_v_q <= request_enable_query | completion_enable_query;
      if (request_enable_query) begin
        en_q <= rqs_q;
      end else if (completion_enable_query) begin
        en_q <= opc_q;
      end
    end
  end

  // Registered count for the observation port
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= lifo_count;
    end
  end

  assign srq_out = srq_q;
  assign serial_poll_status_byte = stb_q;
  assign poll_valid = poll_v_q;
  assign event_code = evc_q;
  assign event_valid = evc_v_q;
  assign enable_state = en_q;
  assign enable_valid = en_v_q;
  assign rqs_enabled = rqs_q;
  assign opc_enabled = opc_q;
  assign events_stored = cnt_q;

  // Request only while enabled and something waits
  property p_srq_cause;
    @(posedge sys_clk) disable iff (sys_rst)
      srq_q |-> $past(rqs_q) && $past(latest_v_q);
  endproperty
  chk_srq_needs_event: assert property (p_srq_cause) else $error("SRQ without cause");

  chk_poll_drops_srq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    serial_poll |=> !srq_q) else $error("SRQ held after poll");

  // Two bytes waiting, the first one polled away, nothing new arriving
  sequence s_two_events;
    latest_v_q && pending_v_q && !hit && !serial_poll ##1 serial_poll && !hit;
  endsequence
  // Request allowed again; a back-to-back poll would rightly keep SRQ low
  sequence s_may_request;
    rqs_q && !serial_poll && !(latest_opc_q && !opc_q);
  endsequence
  chk_srq_reassert: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_two_events ##1 s_may_request |-> ##[1:2] srq_q)
    else $error("SRQ not reasserted");

  chk_empty_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    serial_poll && !latest_v_q |=> stb_q == STB_NONE) else $error("nonzero empty status");

  chk_opc_masked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    meas_signal_done && !opc_q && !(|ev[EV_DEVICE:0]) && !latest_v_q && !serial_poll
    |=> !latest_v_q) else $error("masked completion stored");

  chk_power_code: assert property (@(posedge sys_clk) disable iff (sys_rst)
    power_on_ev && !serial_poll |=> latest_q == STB_POWER_ON) else $error("power byte wrong");

  chk_query_onoff: assert property (@(posedge sys_clk) disable iff (sys_rst)
    request_enable_query |=> en_v_q && en_q == $past(rqs_q)) else $error("bad enable answer");

  chk_lifo_newest: assert property (@(posedge sys_clk) disable iff (sys_rst)
    meas_sweep_done && !(|ev[EV_MEAS_SIG:0]) ##1 event_query && !hit
    |=> evc_q == EVC_MEAS_SWEEP) else $error("LIFO not newest");

  chk_lifo_bound: assert property (@(posedge sys_clk) disable iff (sys_rst)
    lifo_count <= DEPTH[$clog2(DEPTH+1)-1:0]) else $error("LIFO overfilled");

  // Poll answer carries the stored fields and the live request bit
  chk_poll_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    serial_poll |=> poll_v_q) else $error("poll not answered");

  chk_poll_srq_bit: assert property (@(posedge sys_clk) disable iff (sys_rst)
    serial_poll && latest_v_q |=> stb_q[SRQ_BIT] == $past(srq_q))
    else $error("SRQ bit wrong");

  chk_poll_fields: assert property (@(posedge sys_clk) disable iff (sys_rst)
    serial_poll && latest_v_q
    |=> stb_q[CODE_LSB +: CODE_W] == $past(latest_q[CODE_LSB +: CODE_W])
    && stb_q[ABNORMAL_BIT] == $past(latest_q[ABNORMAL_BIT]))
    else $error("status fields wrong");

  // Each event kind from internal error to sweep done, bar measure-signal, lands its own byte when nothing more urgent comes with it; sweep also needs opc_q
  chk_internal_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
    internal_err_ev && !power_on_ev |=> latest_q == STB_INTERNAL_ERROR)
    else $error("internal byte wrong");

  chk_exec_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
    exec_err_ev && !(|ev[EV_INTERNAL:0]) |=> latest_q == STB_EXEC_ERROR)
    else $error("execution byte wrong");

  chk_cmd_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cmd_err_ev && !(|ev[EV_EXEC:0]) |=> latest_q == STB_CMD_ERROR)
    else $error("command byte wrong");

  chk_recover_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
    supply_recover_ev && !(|ev[EV_CMD:0]) |=> latest_q == STB_SUPPLY_RECOVER)
    else $error("recovery byte wrong");

  chk_user_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
    single_btn && fast_shift_held && !(|ev[EV_RECOVER:0]) |=> latest_q == STB_USER_REQ)
    else $error("user byte wrong");

  chk_device_entry: assert property (@(posedge sys_clk) disable iff (sys_rst)
    device_ev && !(|ev[EV_DEVICE-1:0])
    |=> latest_q == STB_DEVICE_EVENT && lifo_top == $past(ev_code_in))
    else $error("device entry wrong");

  chk_sweep_entry: assert property (@(posedge sys_clk) disable iff (sys_rst)
    meas_sweep_done && opc_q && !(|ev[EV_MEAS_SIG:0])
    |=> latest_q == STB_OP_COMPLETE && lifo_top == EVC_MEAS_SWEEP)
    else $error("sweep entry wrong");

  // Store keeps counting while requests are off, and stops at full
  chk_rqs_off_counts: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !rqs_q && hit && lifo_count != DEPTH[$clog2(DEPTH+1)-1:0]
    |=> lifo_count > $past(lifo_count)) else $error("masked event not stored");

  chk_full_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hit && lifo_count == DEPTH[$clog2(DEPTH+1)-1:0]
    |=> lifo_count == $past(lifo_count)) else $error("full store grew");

  chk_rqs_mask: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !rqs_q |=> !srq_q) else $error("SRQ while disabled");

  // Query answers
  chk_empty_query: assert property (@(posedge sys_clk) disable iff (sys_rst)
    event_query && !hit && lifo_count == '0 |=> evc_q == EVC_NONE)
    else $error("empty query nonzero");

  chk_opc_query: assert property (@(posedge sys_clk) disable iff (sys_rst)
    completion_enable_query && !request_enable_query |=> en_v_q && en_q == $past(opc_q))
    else $error("bad completion answer");
endmodule

// ==== gpib_controller_model.sv ====
`timescale 1ns/1ps
// Bus controller: serial polls and event queries, one strobe at a time
module gpib_controller_model (
  // Clock
  input wire logic sys_clk,
  // Device answers
  input wire logic [7:0] serial_poll_status_byte,
  input wire logic poll_valid,
  input wire logic [9:0] event_code,
  input wire logic event_valid,
  // Requests to the device
  output logic serial_poll,
  output logic event_query
);
  // Idle strobes from time zero
  initial begin
    serial_poll = 1'b0;
    event_query = 1'b0;
  end
  // Poll and take the byte on the answer pulse; bounded so a dead device shows as X
  task automatic do_poll(output logic [7:0] stb);
    int n;
    @(negedge sys_clk);
    serial_poll = 1'b1;
    @(negedge sys_clk);
    serial_poll = 1'b0;
    for (n = 0; n < 4 && poll_valid !== 1'b1; n++) @(negedge sys_clk);
    stb = (poll_valid === 1'b1) ? serial_poll_status_byte : 8'hXX;
  endtask
  // Ask for the newest unread event code
  task automatic do_query(output logic [9:0] code);
    int n;
    @(negedge sys_clk);
    event_query = 1'b1;
    @(negedge sys_clk);
    event_query = 1'b0;
    for (n = 0; n < 4 && event_valid !== 1'b1; n++) @(negedge sys_clk);
    code = (event_valid === 1'b1) ? event_code : {10{1'bx}};
  endtask
endmodule

// ==== gpib_status_srq_reporter_bench.sv ====
`timescale 1ns/1ps
module gpib_status_srq_reporter_bench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [8:0] evv = '0;
  logic [9:0] ev_code_in = '0;
  logic rqs_cmd = 1'b0, opc_cmd = 1'b0, arg_on = 1'b0, rqs_qry = 1'b0, opc_qry = 1'b0;
  logic serial_poll, event_query, srq_out, poll_valid, event_valid;
  logic enable_state, enable_valid, rqs_enabled, opc_enabled;
  logic [7:0] stb_seen, stb_seen_w;
  logic [9:0] event_code, code_seen, c;
  logic [3:0] events_stored;
  logic [9:0] codes [0:10];
  int num_errors = 0, total_checks = 0, cyc = 0, seed = 20783;

  // 100 ns period
  always #50 sys_clk = ~sys_clk;

  gpib_status_srq_reporter #(.DEPTH(10)) u_gpib_status_srq_reporter (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .power_on_ev(evv[0]), .internal_err_ev(evv[1]), .exec_err_ev(evv[2]),
    .cmd_err_ev(evv[3]), .supply_recover_ev(evv[4]), .single_btn(evv[5]),
    .fast_shift_held(evv[5]), .device_ev(evv[6]), .meas_signal_done(evv[7]),
    .meas_sweep_done(evv[8]), .ev_code_in(ev_code_in),
    .service_request_enable_cmd(rqs_cmd), .completion_request_enable_cmd(opc_cmd),
    .cmd_arg_on(arg_on), .request_enable_query(rqs_qry),
    .completion_enable_query(opc_qry), .event_query(event_query),
    .serial_poll(serial_poll), .srq_out(srq_out),
    .serial_poll_status_byte(stb_seen_w), .poll_valid(poll_valid),
    .event_code(event_code), .event_valid(event_valid), .enable_state(enable_state),
    .enable_valid(enable_valid), .rqs_enabled(rqs_enabled), .opc_enabled(opc_enabled),
    .events_stored(events_stored)
  );

  gpib_controller_model u_gpib_controller_model (
    .sys_clk(sys_clk), .serial_poll_status_byte(stb_seen_w), .poll_valid(poll_valid),
    .event_code(event_code), .event_valid(event_valid),
    .serial_poll(serial_poll), .event_query(event_query)
  );

  // Status byte per event kind, bit 7 as the table gives it
  function automatic logic [7:0] stb_of(int k);
    case (k)
      0: return 8'h41;
      1: return 8'h63;
      2: return 8'h62;
      3: return 8'h61;
      4: return 8'h45;
      5: return 8'h43;
      6: return 8'hC0;
      default: return 8'h42;
    endcase
  endfunction
  // Completions carry fixed codes, all else the supplied one
  function automatic logic [9:0] code_of(int k, logic [9:0] cin);
    return (k == 7) ? 10'h192 : (k == 8) ? 10'h196 : cin;
  endfunction

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One-cycle event strobe with its code
  task automatic fire(int k, logic [9:0] cin);
    @(negedge sys_clk);
    ev_code_in = cin;
    evv = 9'h001 << k;
    @(negedge sys_clk);
    evv = '0;
  endtask
  // Enable command, which 0 for service requests, 1 for completions
  task automatic set_en(bit which, bit on);
    @(negedge sys_clk);
    arg_on = on;
    rqs_cmd = !which;
    opc_cmd = which;
    @(negedge sys_clk);
    rqs_cmd = 1'b0;
    opc_cmd = 1'b0;
  endtask
  task automatic en_query(bit which, bit exp);
    @(negedge sys_clk);
    rqs_qry = !which;
    opc_qry = which;
    @(negedge sys_clk);
    rqs_qry = 1'b0;
    opc_qry = 1'b0;
    check("enable_answer", {enable_valid, enable_state}, {1'b1, exp});
  endtask
  task automatic poll_is(logic [7:0] exp);
    u_gpib_controller_model.do_poll(stb_seen);
    check("status_byte", stb_seen, exp);
  endtask
  task automatic query_is(logic [9:0] exp);
    u_gpib_controller_model.do_query(code_seen);
    check("event_code", code_seen, exp);
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    check("srq_idle", srq_out, 1'b0);
    check("enables_reset", {rqs_enabled, opc_enabled}, 2'b11);
    poll_is(8'h00);
    // Each event kind raises SRQ, answers its byte, clears on poll
    for (int k = 0; k < 9; k++) begin
      c = 10'($random(seed));
      fire(k, c);
      repeat (2) @(negedge sys_clk);
      check("srq_raised", srq_out, 1'b1);
      poll_is(stb_of(k));
      check("srq_cleared", srq_out, 1'b0);
      query_is(code_of(k, c));
    end
    // Query straight after a completion returns that completion's code
    fork
      fire(8, 10'h000);
      begin
        @(negedge sys_clk);
        query_is(10'h196);
      end
    join
    check("srq_opc", srq_out, 1'b1);
    poll_is(8'h42);
    // Three events: latest and one pending survive, codes newest first
    for (int k = 0; k < 3; k++) codes[k] = 10'($random(seed));
    fire(6, codes[0]);
    fire(1, codes[1]);
    fire(0, codes[2]);
    repeat (2) @(negedge sys_clk);
    poll_is(8'h41);
    @(negedge sys_clk);
    check("srq_again", srq_out, 1'b1);
    poll_is(8'h63);
    @(negedge sys_clk);
    check("srq_done", srq_out, 1'b0);
    poll_is(8'h00);
    for (int k = 2; k >= 0; k--) query_is(codes[k]);
    // Completion masked: no request, code still queued
    set_en(1'b1, 1'b0);
    check("opc_enabled", opc_enabled, 1'b0);
    en_query(1'b1, 1'b0);
    fire(7, 10'h000);
    repeat (3) @(negedge sys_clk);
    check("srq_opc_masked", srq_out, 1'b0);
    poll_is(8'h00);
    query_is(10'h192);
    set_en(1'b1, 1'b1);
    // Requests masked: eleven events, oldest dropped
    set_en(1'b0, 1'b0);
    check("rqs_enabled", rqs_enabled, 1'b0);
    en_query(1'b0, 1'b0);
    for (int i = 0; i < 11; i++) begin
      codes[i] = 10'($random(seed));
      fire(6, codes[i]);
    end
    repeat (2) @(negedge sys_clk);
    check("srq_rqs_masked", srq_out, 1'b0);
    check("events_stored", events_stored, 4'hA);
    poll_is(8'h80);
    poll_is(8'h80);
    poll_is(8'h00);
    for (int i = 10; i > 0; i--) query_is(codes[i]);
    query_is(10'h000);
    // Event held under the mask shows once the mask is lifted
    c = 10'($random(seed));
    fire(3, c);
    set_en(1'b0, 1'b1);
    en_query(1'b0, 1'b1);
    repeat (2) @(negedge sys_clk);
    check("srq_unmasked", srq_out, 1'b1);
    poll_is(8'h61);
    query_is(c);
    give_verdict();
  end
endmodule
